/* asf_pkg.sv */
package asf_pkg;

  // Printed offsets (register index); byte address is four times index
  localparam logic [7:0] ASF_IDX_XDATA8     = 8'h08;
  localparam logic [7:0] ASF_IDX_ZDATA8     = 8'h0A;
  localparam logic [7:0] ASF_IDX_STATUS     = 8'h0B;
  localparam logic [7:0] ASF_IDX_DATA_HI_LO = 8'h0E;
  localparam logic [7:0] ASF_IDX_DATA_HI_HI = 8'h17;
  // Own registers for events, mask and control
  localparam logic [7:0] ASF_IDX_IRQ_STAT   = 8'h40;
  localparam logic [7:0] ASF_IDX_IRQ_MASK   = 8'h41;
  localparam logic [7:0] ASF_IDX_CTRL       = 8'h42;

  // Status bit positions
  localparam int ASF_BIT_UPSET = 7;
  localparam int ASF_BIT_AWAKE = 6;
  localparam int ASF_BIT_STILL = 5;
  localparam int ASF_BIT_MOTN  = 4;
  localparam int ASF_BIT_OVRN  = 3;
  localparam int ASF_BIT_LEVEL = 2;
  localparam int ASF_BIT_AVAIL = 1;
  localparam int ASF_BIT_DRDY  = 0;

  // Control field positions
  localparam int ASF_CTRL_CHAIN_LSB = 0;
  localparam int ASF_CTRL_FIFO_LSB  = 2;

  // Reset values
  localparam logic [7:0] ASF_RST_STATUS = 8'h40;
  localparam logic [7:0] ASF_RST_Z_ACCEL_COARSE_BYTE  = 8'h00;
  localparam logic [7:0] ASF_RST_MASK   = 8'h00;
  localparam logic [3:0] ASF_RST_CTRL   = 4'h0;

  // Detector chaining and FIFO policy codes
  localparam logic [1:0] ASF_CHAIN_DEFAULT = 2'h0;
  localparam logic [1:0] ASF_FIFO_OLDEST   = 2'h2;

  typedef struct packed {
    logic        sample_stb;
    logic [13:0] z_sample;
    logic        still_det;
    logic        motion_det;
    logic        awake_state;
    logic        fifo_full;
    logic        fifo_push;
    logic        fifo_nonempty;
    logic        fifo_at_level;
  } asf_sense_t;

  // Sample write gate back to the FIFO
  typedef struct packed {
    logic write_block;
  } asf_fifo_ctl_t;

endpackage

/* asf_status_bank.sv */
`timescale 1ns/1ps
module asf_status_bank
  import asf_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  soft_reset_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic                       pready_o,
  output logic [31:0]                prdata_o,
  output logic                       pslverr_o,
  // Sensor side
  input  wire asf_pkg::asf_sense_t   sense_i,
  input  wire logic                  fifo_pop_i,
  output asf_pkg::asf_fifo_ctl_t     fifo_ctl_o,
  // Interrupt
  output logic                       irq_o
);
  import asf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic is_data_idx(input logic [7:0] idx);
    is_data_idx = (idx >= ASF_IDX_XDATA8 && idx <= ASF_IDX_ZDATA8) ||
                  (idx >= ASF_IDX_DATA_HI_LO && idx <= ASF_IDX_DATA_HI_HI);
  endfunction

  logic [7:0] status_reg;
  logic [7:0] z_accel_coarse_byte_reg;
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_mask_reg;
  logic [3:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic        overrun_reg;
  logic        pend_reg;

  wire logic       aligned   = (paddr_i[1:0] == 2'h0);
  wire logic [7:0] idx       = paddr_i[9:2];
  wire logic       in_range  = aligned && (paddr_i[11:10] == 2'h0);
  wire logic       hit_z     = in_range && idx == ASF_IDX_ZDATA8;
  wire logic       hit_stat  = in_range && idx == ASF_IDX_STATUS;
  wire logic       hit_istat = in_range && idx == ASF_IDX_IRQ_STAT;
  wire logic       hit_imask = in_range && idx == ASF_IDX_IRQ_MASK;
  wire logic       hit_ctrl  = in_range && idx == ASF_IDX_CTRL;
  wire logic       hit_data  = in_range && is_data_idx(idx);
  wire logic       hit_any   = hit_z | hit_stat | hit_istat | hit_imask | hit_ctrl | hit_data;
  wire logic       acc_done  = psel_i && penable_i;
  wire logic       wr_done   = acc_done && pwrite_i && hit_any;
  wire logic       data_rd   = psel_i && !pwrite_i && hit_data;
  wire logic       rd_start  = data_rd && !penable_i;
  wire logic       rd_end    = data_rd && penable_i;
  wire logic       rd_busy   = data_rd;
  wire logic [1:0] chain_mode  = ctrl_reg[ASF_CTRL_CHAIN_LSB +: 2];
  wire logic [1:0] fifo_policy = ctrl_reg[ASF_CTRL_FIFO_LSB +: 2];

  assign pready_o  = 1'b1;
  assign pslverr_o = acc_done && !hit_any;
  assign prdata_o  = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Status next values
  wire logic awake_bit = (chain_mode == ASF_CHAIN_DEFAULT) ? 1'b1 : sense_i.awake_state;
  wire logic ovr_set   = sense_i.fifo_full && sense_i.fifo_push &&
                         (fifo_policy == ASF_FIFO_OLDEST);
  wire logic ovr_next  = ovr_set | (overrun_reg & ~fifo_pop_i);
  wire logic drdy_cur  = status_reg[ASF_BIT_DRDY];
  wire logic upset_next = soft_reset_i ? 1'b1 : (wr_done ? 1'b0 : status_reg[ASF_BIT_UPSET]);

  logic drdy_next;
  logic pend_next;
  always_comb
  begin
    drdy_next = drdy_cur;
    pend_next = pend_reg;
    if (rd_start)
    begin
      drdy_next = 1'b0;
      pend_next = sense_i.sample_stb | (drdy_cur & pend_reg);
    end
    else if (rd_busy && !rd_end)
    begin
      pend_next = pend_reg | sense_i.sample_stb;
    end
    else if (rd_end)
    begin
      drdy_next = pend_reg | sense_i.sample_stb;
      pend_next = 1'b0;
    end
    else if (sense_i.sample_stb)
    begin
      drdy_next = 1'b1;
    end
  end

  wire logic [7:0] status_next = {upset_next, awake_bit, sense_i.still_det, sense_i.motion_det,
                                  ovr_next, sense_i.fifo_at_level, sense_i.fifo_nonempty,
                                  drdy_next};
  wire logic [7:0] rd_mux =
    hit_z     ? z_accel_coarse_byte_reg :
    hit_stat  ? status_reg :
    hit_istat ? irq_stat_reg :
    hit_imask ? irq_mask_reg :
    hit_ctrl  ? {4'h0, ctrl_reg} : 8'h00;
  wire logic [7:0] rise    = status_next & ~status_reg;
  wire logic       wr_istat = wr_done && hit_istat;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      status_reg  <= ASF_RST_STATUS | 8'h80;
      z_accel_coarse_byte_reg   <= ASF_RST_Z_ACCEL_COARSE_BYTE;
      overrun_reg <= 1'b0;
      pend_reg    <= 1'b0;
    end
    else
    begin
      status_reg  <= status_next;
      overrun_reg <= ovr_next;
      pend_reg    <= pend_next;
      if (sense_i.sample_stb)
        z_accel_coarse_byte_reg <= sense_i.z_sample[13:6];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      irq_stat_reg <= 8'h00;
      irq_mask_reg <= ASF_RST_MASK;
      ctrl_reg     <= ASF_RST_CTRL;
      prdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      irq_stat_reg <= rise | (irq_stat_reg & ~(wr_istat ? pwdata_i[7:0] : 8'h00));
      if (wr_done && hit_imask)
        irq_mask_reg <= pwdata_i[7:0];
      if (wr_done && hit_ctrl)
        ctrl_reg <= pwdata_i[3:0];
      if (psel_i && !penable_i && !pwrite_i)
        prdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);
  assign fifo_ctl_o.write_block = overrun_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_read_start;
    psel_i && !penable_i && !pwrite_i && hit_data;
  endsequence

  // Read setup with a sample arriving in the same cycle
  sequence s_read_sample;
    psel_i && !penable_i && !pwrite_i && hit_data && sense_i.sample_stb;
  endsequence

  // Access phase of a data register read
  sequence s_read_access;
    psel_i && penable_i && !pwrite_i && hit_data;
  endsequence

  // Read setup that finds data-ready low
  sequence s_read_low;
    psel_i && !penable_i && !pwrite_i && hit_data && !status_reg[ASF_BIT_DRDY];
  endsequence

  a_upset_write_clear: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    wr_done && !soft_reset_i |=> !status_reg[ASF_BIT_UPSET])
    else $error("upset flag not cleared by write");
  a_upset_soft_set: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    soft_reset_i |=> status_reg[ASF_BIT_UPSET])
    else $error("upset flag not set by soft reset");
  a_awake_held_high: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    chain_mode == ASF_CHAIN_DEFAULT |=> status_reg[ASF_BIT_AWAKE])
    else $error("awake bit not held high");
  a_drdy_clear_start: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_read_start |=> !status_reg[ASF_BIT_DRDY])
    else $error("data ready not cleared at read start");
  a_drdy_hold_read: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_read_start ##1 (psel_i && penable_i) |-> !status_reg[ASF_BIT_DRDY])
    else $error("data ready set during read");
  a_drdy_set_after: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_read_sample ##1 s_read_access |=> status_reg[ASF_BIT_DRDY])
    else $error("pending sample lost after read");
  a_drdy_low_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_read_low and s_read_sample |=> !status_reg[ASF_BIT_DRDY])
    else $error("data ready rose before read ended");
  a_z_accel_coarse_byte_capture: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    sense_i.sample_stb |=> z_accel_coarse_byte_reg == $past(sense_i.z_sample[13:6]))
    else $error("z byte does not hold top sample bits");
  a_z_accel_coarse_byte_wr_ignored: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    wr_done && hit_z && !sense_i.sample_stb |=> $stable(z_accel_coarse_byte_reg))
    else $error("z byte changed by host write");
  a_status_reset: assert property (@(posedge core_clk_i)
    !reset_n_i |=> status_reg == (ASF_RST_STATUS | 8'h80))
    else $error("status reset value wrong");
  a_awake_chained: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    chain_mode != ASF_CHAIN_DEFAULT |=> status_reg[ASF_BIT_AWAKE] == $past(sense_i.awake_state))
    else $error("awake bit does not follow state");
  a_still_follow: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 status_reg[ASF_BIT_STILL] == $past(sense_i.still_det))
    else $error("stillness flag mismatch");
  a_motion_follow: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 status_reg[ASF_BIT_MOTN] == $past(sense_i.motion_det))
    else $error("motion flag mismatch");
  a_level_follow: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 status_reg[ASF_BIT_LEVEL] == $past(sense_i.fifo_at_level))
    else $error("queue level flag mismatch");
  a_ovr_set_full: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ovr_set |=> status_reg[ASF_BIT_OVRN])
    else $error("overrun not flagged on full push");
  a_ovr_held_pop: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    status_reg[ASF_BIT_OVRN] && !fifo_pop_i |=> status_reg[ASF_BIT_OVRN])
    else $error("overrun dropped without FIFO read");
  a_status_capture: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    psel_i && !penable_i && !pwrite_i && hit_stat |=> prdata_reg[7:0] == $past(status_reg))
    else $error("status read data wrong");
  a_drdy_new_sample: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    sense_i.sample_stb && !psel_i |=> status_reg[ASF_BIT_DRDY])
    else $error("new sample did not set data ready");
  a_ovr_policy_only: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !status_reg[ASF_BIT_OVRN] && fifo_policy != ASF_FIFO_OLDEST |=> !status_reg[ASF_BIT_OVRN])
    else $error("overrun flagged outside oldest-saved policy");
  a_ovr_blocks_fifo: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    status_reg[ASF_BIT_OVRN] |-> fifo_ctl_o.write_block)
    else $error("FIFO writes not blocked on overrun");
  a_z_accel_coarse_byte_ro: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !sense_i.sample_stb |=> $stable(z_accel_coarse_byte_reg))
    else $error("z byte changed without sample");
  a_fifo_avail: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 status_reg[ASF_BIT_AVAIL] == $past(sense_i.fifo_nonempty))
    else $error("available flag mismatch");

endmodule

/* asf_sense_model.sv */
`timescale 1ns/1ps
module asf_sense_model
  import asf_pkg::*;
(
  input  wire logic                   core_clk_i,
  input  wire asf_pkg::asf_fifo_ctl_t fifo_ctl_i,
  output asf_pkg::asf_sense_t         sense_o
);
  initial sense_o = '0;
  // Strobes last one cycle
  always @(posedge core_clk_i)
  begin
    if (sense_o.sample_stb) sense_o.sample_stb <= 1'b0;
    if (sense_o.fifo_push) sense_o.fifo_push <= 1'b0;
  end
  task automatic fire(input logic [13:0] z);
    sense_o.z_sample <= z;
    sense_o.sample_stb <= 1'b1;
  endtask
  // No push while the gate is closed
  task automatic push();
    if (fifo_ctl_i.write_block !== 1'b1) sense_o.fifo_push <= 1'b1;
  endtask
  task automatic levels(input logic [5:0] v);
    {sense_o.still_det, sense_o.motion_det, sense_o.awake_state} <= v[5:3];
    {sense_o.fifo_full, sense_o.fifo_nonempty, sense_o.fifo_at_level} <= v[2:0];
  endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import asf_pkg::*;
  logic          core_clk_i, reset_n_i, soft_reset_i, psel, penable, pwrite, fifo_pop, pready, pslverr, irq, err;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, q;
  asf_sense_t    sense;
  asf_fifo_ctl_t fctl;
  int            miscompares, checks_done;

  asf_status_bank DUT (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .soft_reset_i(soft_reset_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .sense_i(sense),
    .fifo_pop_i(fifo_pop), .fifo_ctl_o(fctl), .irq_o(irq));
  asf_sense_model sens (.core_clk_i(core_clk_i), .fifo_ctl_i(fctl), .sense_o(sense));

  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic smp);
    repeat (2) @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    if (smp) sens.fire(14'h1555);
    do @(posedge core_clk_i); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n, input logic smp = 1'b0);
    apb(1'b0, a, 32'h0, smp);
    check(n, q, e);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_upset();
    rd(12'h02C, 32'h000000C0, "status reset");
    rd(12'h028, 32'h00000000, "zbyte reset");
    apb(1'b1, 12'h02C, 32'hFF, 1'b0);
    apb(1'b1, 12'h028, 32'hFF, 1'b0);
    rd(12'h02C, 32'h00000040, "status after write");
    rd(12'h028, 32'h00000000, "zbyte after write");
    @(posedge core_clk_i) soft_reset_i <= 1'b1;
    @(posedge core_clk_i) soft_reset_i <= 1'b0;
    rd(12'h02C, 32'h000000C0, "status soft reset");
    apb(1'b1, 12'h108, 32'h0, 1'b0);
  endtask
  task automatic t_ready();
    @(posedge core_clk_i) sens.fire(14'h2A5C);
    rd(12'h02C, 32'h00000041, "ready set");
    rd(12'h028, 32'h000000A9, "zbyte old", 1'b1);
    rd(12'h02C, 32'h00000041, "ready kept");
    rd(12'h028, 32'h00000055, "zbyte new");
    rd(12'h02C, 32'h00000040, "ready cleared");
    rd(12'h020, 32'h00000000, "xbyte", 1'b1);
    rd(12'h02C, 32'h00000041, "ready after read");
    apb(1'b0, 12'h05C, 32'h0, 1'b0);
    rd(12'h02C, 32'h00000040, "ready top range");
  endtask
  task automatic t_flags();
    @(posedge core_clk_i) sens.levels(6'b110011);
    rd(12'h02C, 32'h00000076, "flags unchained");
    apb(1'b1, 12'h108, 32'h1, 1'b0);
    rd(12'h02C, 32'h00000036, "flags chained");
    @(posedge core_clk_i) sens.levels(6'b000100);
    apb(1'b1, 12'h108, 32'h0, 1'b0);
    @(posedge core_clk_i) sens.push();
    rd(12'h02C, 32'h00000040, "no overrun");
    apb(1'b1, 12'h108, 32'h8, 1'b0);
    @(posedge core_clk_i) sens.push();
    rd(12'h02C, 32'h00000048, "overrun");
    check("gate", {31'h0, fctl.write_block}, 32'h1);
    @(posedge core_clk_i) fifo_pop <= 1'b1;
    @(posedge core_clk_i) fifo_pop <= 1'b0;
    rd(12'h02C, 32'h00000040, "overrun cleared");
    check("gate open", {31'h0, fctl.write_block}, 32'h0);
  endtask
  task automatic t_irq();
    apb(1'b1, 12'h100, 32'hFF, 1'b0);
    @(posedge core_clk_i) sens.fire(14'h0);
    rd(12'h100, 32'h00000001, "event");
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, 12'h104, 32'h1, 1'b0);
    repeat (2) @(posedge core_clk_i);
    check("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h100, 32'h1, 1'b0);
    rd(12'h100, 32'h00000000, "event cleared");
    check("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, 12'h300, 32'h0, 1'b0);
    check("unmapped", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h02D, 32'h0, 1'b0);
    check("unaligned", {31'h0, err}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    {reset_n_i, soft_reset_i, psel, penable, pwrite, fifo_pop} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (12) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_upset();
    t_ready();
    t_flags();
    t_irq();
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    tally_and_finish();
  end
endmodule
